// ### design/adc_ctl_pkg.sv
// Shared constants for the converter control block
//
// Behaviour
// - One converter serves four analog inputs, 8-bit or 9-bit result by build.
// - 8-bit build puts result bits 7..0 in one readable result byte.
// - 9-bit build: high byte holds bits 8..1, low byte bit 7 holds bit 0.
// - Channel field routes one of four inputs; software keeps its top bit zero.
// - Pin config field 100 or higher makes all four shared pins analog.
// - Pin config zero returns pins to digital use and powers converter down.
// - Start bit driven 0 then 1 then 0 begins one conversion.
// - While start is high the converter is held reset and pending reads one.
// - Pending flag clears to zero when a conversion finishes.
// - End of conversion sets the request flag; interrupt only when enabled.
// - Divider select 00, 01, 10 divide by 2, 8, 32; 11 undefined.
// - A conversion lasts 64 periods in 8-bit build, 76 in 9-bit build.
// - Analog pins override port direction and drop their pull-high.
`default_nettype none
package adc_ctl_pkg;
    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [2:0] ADDR_RESULT_LOW = 3'h0;
    localparam logic [2:0] ADDR_RESULT_HIGH = 3'h1;
    localparam logic [2:0] ADDR_CONTROL = 3'h2;
    localparam logic [2:0] ADDR_CLK_SEL = 3'h3;
    localparam logic [2:0] ADDR_IRQ_STATUS = 3'h4;
    localparam logic [2:0] ADDR_IRQ_MASK = 3'h5;
    // ------------------------------------------------------------------
    // Control register fields
    // ------------------------------------------------------------------
    localparam int CTL_START_BIT = 7;
    localparam int CTL_PENDING_BIT = 6;
    localparam int CTL_PCFG_LSB = 3;
    localparam int CTL_CHAN_LSB = 0;
    localparam logic [2:0] PCFG_ALL_ANALOG = 3'h4;
    localparam logic [2:0] PCFG_OFF = 3'h0;
    localparam int IRQ_DONE_BIT = 0;
    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [2:0] CHAN_RESET = 3'h0;
    localparam logic [2:0] PCFG_RESET = 3'h0;
    localparam logic [1:0] DIV_SEL_RESET = 2'h0;
    localparam logic PENDING_RESET = 1'b1;
    // ------------------------------------------------------------------
    // Divider codes and ratios
    // ------------------------------------------------------------------
    localparam logic [1:0] DIV_SEL_2 = 2'h0;
    localparam logic [1:0] DIV_SEL_8 = 2'h1;
    localparam logic [1:0] DIV_SEL_32 = 2'h2;
    localparam logic [4:0] DIV_LAST_2 = 5'h01;
    localparam logic [4:0] DIV_LAST_8 = 5'h07;
    localparam logic [4:0] DIV_LAST_32 = 5'h1F;
    // ------------------------------------------------------------------
    // Conversion lengths in conversion clock periods
    // ------------------------------------------------------------------
    localparam logic [6:0] CONV_PERIODS_8 = 7'd64;
    localparam logic [6:0] CONV_PERIODS_9 = 7'd76;
    localparam int RES_BITS_MAX = 9;
endpackage : adc_ctl_pkg
`default_nettype wire

// ### design/conv_if.sv
// Internal carrier between control, clock divider and conversion core
`default_nettype none
interface conv_if;
    logic [1:0] div_sel;
    logic tick;
    logic hold;
    logic [8:0] sample;
    logic done;
    logic [8:0] result;
    modport div (input div_sel, output tick);
    modport core (input tick, hold, sample, output done, result);
    modport ctl (output div_sel, hold, sample, input tick, done, result);
endinterface : conv_if
`default_nettype wire

// ### design/conv_clk_div.sv
// Conversion clock divider producing one-cycle enable pulses
`default_nettype none
module conv_clk_div
    import adc_ctl_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Divider control and tick
    conv_if.div cif
);
    logic [4:0] cnt_reg;
    logic [4:0] last;

    // Ratio decode; code 11 stops the tick as its rate is undefined
    always_comb begin
        case (cif.div_sel)
            DIV_SEL_2: last = DIV_LAST_2;
            DIV_SEL_8: last = DIV_LAST_8;
            DIV_SEL_32: last = DIV_LAST_32;
            default: last = 5'h00;
        endcase
    end

    // Free running counter, restarted after it reaches the last count of the chosen ratio
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || last == 5'h00 || cnt_reg >= last) begin
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    assign cif.tick = (last != 5'h00) && (cnt_reg == last);
endmodule : conv_clk_div
`default_nettype wire

// ### design/conv_core.sv
// Conversion core: counts conversion periods and captures the sample
`default_nettype none
module conv_core
    import adc_ctl_pkg::*;
#(
    parameter logic [6:0] CONV_PERIODS = CONV_PERIODS_9
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Tick, hold, sample and completion
    conv_if.core cif
);
    logic armed_reg;
    logic [6:0] per_reg;
    logic done_reg;
    logic [8:0] result_reg;

    // Hold resets the core and arms it; counting starts once hold drops
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            armed_reg <= 1'b0;
            per_reg <= 7'd0;
        end else if (cif.hold) begin
            armed_reg <= 1'b1;
            per_reg <= 7'd0;
        end else if (armed_reg && cif.tick) begin
            if (per_reg == CONV_PERIODS - 7'd1) begin
                armed_reg <= 1'b0;
                per_reg <= 7'd0;
            end else begin
                per_reg <= per_reg + 7'd1;
            end
        end
    end

    // Completion pulse and sample capture on the final period
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            done_reg <= 1'b0;
            result_reg <= 9'h000;
        end else begin
            done_reg <= !cif.hold && armed_reg && cif.tick &&
                (per_reg == CONV_PERIODS - 7'd1);
            if (!cif.hold && armed_reg && cif.tick &&
                per_reg == CONV_PERIODS - 7'd1) begin
                result_reg <= cif.sample;
            end
        end
    end

    assign cif.done = done_reg;
    assign cif.result = result_reg;
endmodule : conv_core
`default_nettype wire

// ### design/adc_sequencer_control.sv
// Top of the converter control block: registers, pins and interrupt
`default_nettype none
module adc_sequencer_control
    import adc_ctl_pkg::*;
#(
    parameter int RES_BITS = RES_BITS_MAX
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Digitised levels of the four analog inputs
    input wire logic [35:0] analog_sample_in,
    // Shared pin control
    output logic [3:0] pin_analog_out,
    output logic converter_power_out,
    // Interrupt
    output logic irq_out
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    localparam logic [6:0] CONV_PERIODS =
        (RES_BITS == 8) ? CONV_PERIODS_8 : CONV_PERIODS_9;

    conv_if cif ();

    // Control and clock select fields
    logic [2:0] chan_reg;
    logic [2:0] pcfg_reg;
    logic start_reg;
    logic pending_reg;
    logic run_reg;
    logic [1:0] div_sel_reg;

    // Results, interrupt and read data
    logic [7:0] res_low_reg;
    logic [7:0] res_high_reg;
    logic irq_stat_reg;
    logic irq_mask_reg;
    logic [7:0] rdata_reg;

    // Sample path and pin side
    logic [35:0] samp_meta_reg;
    logic [35:0] samp_sync_reg;
    logic [35:0] samp_prev_reg;
    logic [35:0] samp_hold_reg;
    logic [3:0] pin_analog_reg;
    logic power_reg;

    // Decoded strobes and completion
    logic wr_ctl;
    logic done_ok;
    logic [8:0] sel_sample;

    // Write decode used by several processes
    function automatic logic wr_hit(input logic [2:0] a);
        wr_hit = reg_wr_in && (reg_addr_in == a);
    endfunction : wr_hit

    assign wr_ctl = wr_hit(ADDR_CONTROL);

    // ------------------------------------------------------------------
    // Submodules
    // ------------------------------------------------------------------
    conv_clk_div u_div (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .cif(cif.div)
    );

    conv_core #(
        .CONV_PERIODS(CONV_PERIODS)
    ) u_core (
        .sys_clk_in(sys_clk_in),
        .sys_rst_in(sys_rst_in),
        .cif(cif.core)
    );

    // Core is held while start is high or the converter is powered off
    assign cif.hold = start_reg || (pcfg_reg == PCFG_OFF);
    assign cif.div_sel = div_sel_reg;

    // ------------------------------------------------------------------
    // Analog sample capture
    // ------------------------------------------------------------------
    // Samples come from outside the clock domain; two flops first
    always_ff @(posedge sys_clk_in) begin
        samp_meta_reg <= analog_sample_in;
        samp_sync_reg <= samp_meta_reg;
    end

    // Each level bit has its own synchroniser, so a word caught while the
    // sensor moves may mix old and new bits; a word is only taken once two
    // successive copies agree. A level that never settles keeps the last.
    always_ff @(posedge sys_clk_in) begin
        samp_prev_reg <= samp_sync_reg;
        if (samp_prev_reg == samp_sync_reg) begin
            samp_hold_reg <= samp_sync_reg;
        end
    end

    // Only the low two channel bits steer the mux; the top bit is stored but ignored
    always_comb begin
        sel_sample = 9'h000;
        case (chan_reg[1:0])
            2'h0: sel_sample = samp_hold_reg[8:0];
            2'h1: sel_sample = samp_hold_reg[17:9];
            2'h2: sel_sample = samp_hold_reg[26:18];
            2'h3: sel_sample = samp_hold_reg[35:27];
            default: sel_sample = 9'h000;
        endcase
    end

    // An 8-bit build sees the upper eight sample bits only
    assign cif.sample = (RES_BITS == 8) ?
        {1'b0, sel_sample[8:1]} : sel_sample;

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    // Channel and pin configuration fields
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            chan_reg <= CHAN_RESET;
            pcfg_reg <= PCFG_RESET;
        end else if (wr_ctl) begin
            chan_reg <= reg_wdata_in[CTL_CHAN_LSB +: 3];
            pcfg_reg <= reg_wdata_in[CTL_PCFG_LSB +: 3];
        end
    end

    // Start bit; its fall releases the core and begins a conversion
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            start_reg <= 1'b0;
        end else if (wr_ctl) begin
            start_reg <= reg_wdata_in[CTL_START_BIT];
        end
    end

    // Run flag: set by a start pulse, cleared by completion or power-down.
    // The core stays armed through power-down, so without it switching
    // the pins back on would complete a conversion no start launched.
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            run_reg <= 1'b0;
        end else if (start_reg) begin
            run_reg <= 1'b1;
        end else if (cif.done || pcfg_reg == PCFG_OFF) begin
            run_reg <= 1'b0;
        end
    end

    // Completion as software sees it; a high start bit suppresses it
    assign done_ok = cif.done && run_reg && !start_reg;

    // Pending: forced high while start is high, cleared by completion
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pending_reg <= PENDING_RESET;
        end else if (start_reg) begin
            pending_reg <= 1'b1;
        end else if (done_ok) begin
            pending_reg <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Clock select register
    // ------------------------------------------------------------------
    // Code 11 is stored and gives no conversion clock; code 00 is too
    // fast for an accurate result unless the system clock is slow
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            div_sel_reg <= DIV_SEL_RESET;
        end else if (wr_hit(ADDR_CLK_SEL)) begin
            div_sel_reg <= reg_wdata_in[1:0];
        end
    end

    // ------------------------------------------------------------------
    // Result bytes
    // ------------------------------------------------------------------
    // Loaded with the completion that clears pending, then held
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            res_low_reg <= 8'h00;
            res_high_reg <= 8'h00;
        end else if (done_ok) begin
            if (RES_BITS == 8) begin
                res_low_reg <= cif.result[7:0];
                res_high_reg <= 8'h00;
            end else begin
                res_low_reg <= {cif.result[0], 7'h00};
                res_high_reg <= cif.result[8:1];
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt status and mask
    // ------------------------------------------------------------------
    // Completion sets the sticky flag; a set beats a same-cycle clear
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            irq_stat_reg <= 1'b0;
        end else if (done_ok) begin
            irq_stat_reg <= 1'b1;
        end else if (wr_hit(ADDR_IRQ_STATUS) &&
            reg_wdata_in[IRQ_DONE_BIT]) begin
            irq_stat_reg <= 1'b0;
        end
    end

    // Mask of the same layout
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            irq_mask_reg <= 1'b0;
        end else if (wr_hit(ADDR_IRQ_MASK)) begin
            irq_mask_reg <= reg_wdata_in[IRQ_DONE_BIT];
        end
    end

    // Level interrupt only while enabled
    assign irq_out = irq_stat_reg && irq_mask_reg;

    // ------------------------------------------------------------------
    // Shared pin control
    // ------------------------------------------------------------------
    // Converter power follows a nonzero pin configuration
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            power_reg <= 1'b0;
        end else begin
            power_reg <= (pcfg_reg != PCFG_OFF);
        end
    end

    // Codes 1..3 give one to three pins; 100 and above give all four
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            pin_analog_reg <= 4'h0;
        end else begin
            if (pcfg_reg >= PCFG_ALL_ANALOG) begin
                pin_analog_reg <= 4'hF;
            end else begin
                case (pcfg_reg)
                    3'h1: pin_analog_reg <= 4'h1;
                    3'h2: pin_analog_reg <= 4'h3;
                    3'h3: pin_analog_reg <= 4'h7;
                    default: pin_analog_reg <= 4'h0;
                endcase
            end
        end
    end

    // A set bit overrides the pin direction and drops the pull-high
    assign pin_analog_out = pin_analog_reg;
    assign converter_power_out = power_reg;

    // ------------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------------
    // Data stand for the one cycle after the strobe, zero otherwise
    // Map: 0 low result, 1 high result, 2 control, 3 clock select,
    // 4 interrupt status, 5 interrupt mask; other addresses read zero
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in || !reg_rd_in) begin
            rdata_reg <= 8'h00;
        end else begin
            case (reg_addr_in)
                ADDR_RESULT_LOW: rdata_reg <= res_low_reg;
                ADDR_RESULT_HIGH: rdata_reg <= res_high_reg;
                ADDR_CONTROL: rdata_reg <= {start_reg, pending_reg,
                    pcfg_reg, chan_reg};
                ADDR_CLK_SEL: rdata_reg <= {6'h00, div_sel_reg};
                ADDR_IRQ_STATUS: rdata_reg <= {7'h00, irq_stat_reg};
                ADDR_IRQ_MASK: rdata_reg <= {7'h00, irq_mask_reg};
                default: rdata_reg <= 8'h00;
            endcase
        end
    end

    assign reg_rdata_out = rdata_reg;
endmodule : adc_sequencer_control
`default_nettype wire

// ### tb/adc_sensor_model.sv
// Behavioural sensors standing behind the four shared pins
`default_nettype none
module adc_sensor_model (
    // Sensor levels from the bench and pin mode from the block
    input wire logic [35:0] level_in,
    input wire logic [3:0] pin_analog_in,
    // Digitised levels seen by the converter
    output logic [35:0] sample_out
);
    timeunit 1ns;
    timeprecision 1ps;
    // A pin in digital use carries port traffic, so never the sensor level
    always_comb begin
        for (int n = 0; n < 4; n++) begin
            sample_out[9*n +: 9] = pin_analog_in[n] ?
                level_in[9*n +: 9] : ~level_in[9*n +: 9];
        end
    end
endmodule : adc_sensor_model
`default_nettype wire

// ### tb/adc_seq_chk.sv
// Assertion checker on the ports of the converter control block
`default_nettype none
module adc_seq_chk
    import adc_ctl_pkg::*;
#(
    parameter int RES_BITS = RES_BITS_MAX
) (
    // Clock and reset
    input wire logic sys_clk_in,
    input wire logic sys_rst_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [7:0] reg_rdata_out,
    // Sensor levels, pins and interrupt
    input wire logic [35:0] analog_sample_in,
    input wire logic [3:0] pin_analog_out,
    input wire logic converter_power_out,
    input wire logic irq_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge sys_clk_in); endclocking
    default disable iff (sys_rst_in);
    // ------------------------------------------------------------
    // Shadow of start bit and divider, cycles since release
    // ------------------------------------------------------------
    logic ctl_wr;
    logic start_reg;
    logic busy_reg;
    logic [1:0] div_reg;
    int since_reg;
    int n_div;
    int n_per;
    assign ctl_wr = reg_wr_in && reg_addr_in == ADDR_CONTROL;
    assign n_div = div_reg == DIV_SEL_2 ? 2 : div_reg == DIV_SEL_8 ? 8 : 32;
    assign n_per = RES_BITS == 8 ? 64 : 76;
    // Busy only for a clean release with pins enabled, so aborts never count
    always_ff @(posedge sys_clk_in) begin
        if (sys_rst_in) begin
            start_reg <= 1'b0;
            busy_reg <= 1'b0;
            div_reg <= DIV_SEL_RESET;
            since_reg <= 0;
        end else begin
            since_reg <= since_reg + 1;
            if (ctl_wr) begin
                start_reg <= reg_wdata_in[CTL_START_BIT];
            end
            if (reg_wr_in && reg_addr_in == ADDR_CLK_SEL) begin
                div_reg <= reg_wdata_in[1:0];
            end
            if (ctl_wr && start_reg && !reg_wdata_in[CTL_START_BIT] &&
                reg_wdata_in[5:3] != PCFG_OFF) begin
                busy_reg <= 1'b1;
                since_reg <= 0;
            end else if (irq_out) begin
                busy_reg <= 1'b0;
            end
        end
    end
    // ------------------------------------------------------------
    // Bus steps
    // ------------------------------------------------------------
    sequence s_wr(logic [2:0] a);
        reg_wr_in && reg_addr_in == a;
    endsequence
    sequence s_rd(logic [2:0] a);
        reg_rd_in && reg_addr_in == a;
    endsequence
    a_rdata_idle: assert property (
        !reg_rd_in |=> reg_rdata_out == 8'h00)
        else $error("read data not idle");
    a_ctl_readback: assert property (
        s_wr(ADDR_CONTROL) ##2 s_rd(ADDR_CONTROL) |=>
        reg_rdata_out[5:0] == $past(reg_wdata_in[5:0], 3))
        else $error("control readback wrong");
    a_div_readback: assert property (
        s_wr(ADDR_CLK_SEL) ##2 s_rd(ADDR_CLK_SEL) |=>
        reg_rdata_out[1:0] == $past(reg_wdata_in[1:0], 3))
        else $error("divider readback wrong");
    a_pending_held: assert property (
        reg_rd_in && reg_addr_in == ADDR_CONTROL && start_reg &&
        $past(start_reg) |=> reg_rdata_out[7:6] == 2'b11)
        else $error("pending not held while start high");
    a_power_track: assert property (
        s_wr(ADDR_CONTROL) |=> ##1 {converter_power_out, |pin_analog_out}
        == {2{$past(reg_wdata_in[5:3], 2) != PCFG_OFF}})
        else $error("power or pins disagree with pin config");
    a_pins_analog: assert property (
        s_wr(ADDR_CONTROL) ##0 reg_wdata_in[5:3] >= PCFG_ALL_ANALOG
        |=> ##1 pin_analog_out == 4'hF)
        else $error("pins not all analog");
    a_irq_masked: assert property (
        s_wr(ADDR_IRQ_MASK) ##0 !reg_wdata_in[IRQ_DONE_BIT] |=> !irq_out)
        else $error("interrupt while masked");
    a_conv_time: assert property (
        $rose(irq_out) && busy_reg |-> since_reg >= (n_per - 1) * n_div - 1
        && since_reg <= n_per * n_div + 4)
        else $error("conversion length wrong");
endmodule : adc_seq_chk
`default_nettype wire

// ### tb/adc_sequencer_control_bench.sv
// Self-checking bench for the converter control block
`default_nettype none
module adc_sequencer_control_bench
    import adc_ctl_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk_in = 1'b0;
    logic sys_rst_in = 1'b1;
    logic [2:0] reg_addr_in = 3'h0;
    logic [7:0] reg_wdata_in = 8'h00;
    logic reg_wr_in = 1'b0;
    logic reg_rd_in = 1'b0;
    logic [7:0] reg_rdata_out;
    logic [35:0] analog_sample_in;
    logic [35:0] level = 36'h0;
    logic [3:0] pin_analog_out;
    logic converter_power_out;
    logic irq_out;
    logic rd_seen = 1'b0;
    logic [15:0] seed = 16'h0038;
    logic [15:0] exp_q[$];
    int err_total = 0;
    int n_checks = 0;
    int cycles = 0;
    adc_sequencer_control #(.RES_BITS(9)) u_adc_sequencer_control (
        .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
        .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
        .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
        .reg_rdata_out(reg_rdata_out), .analog_sample_in(analog_sample_in),
        .pin_analog_out(pin_analog_out),
        .converter_power_out(converter_power_out), .irq_out(irq_out));
    adc_sensor_model u_adc_sensor_model (.level_in(level),
        .pin_analog_in(pin_analog_out), .sample_out(analog_sample_in));
    initial begin
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction : lfsr
    task automatic report_and_stop();
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : report_and_stop
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_wdata_in <= d;
        reg_wr_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    // Expected value and mask go on the queue before the strobe
    task automatic rd(input logic [2:0] a, input logic [7:0] e,
                      input logic [7:0] m);
        exp_q.push_back({m, e});
        @(posedge sys_clk_in);
        reg_addr_in <= a;
        reg_rd_in <= 1'b1;
        @(posedge sys_clk_in);
        reg_rd_in <= 1'b0;
    endtask : rd
    // One conversion on channel ch, divider code dv, sensor level random
    task automatic conv(input logic [1:0] dv, input logic [1:0] ch);
        logic [35:0] lv;
        logic [8:0] s;
        int k;
        seed = lfsr(seed);
        lv = {seed[11:0], seed, seed[7:0]};
        s = lv[9*ch +: 9];
        level <= lv;
        // No code meets the minimum period at 40 MHz; the model loses nothing
        wr(ADDR_CLK_SEL, {6'h00, dv});
        rd(ADDR_CLK_SEL, {6'h00, dv}, 8'h03);
        wr(ADDR_CONTROL, {6'h28, ch});
        wr(ADDR_CONTROL, {6'h08, ch});
        k = 0;
        while (irq_out !== 1'b1 && k < 3000) begin
            @(posedge sys_clk_in);
            k++;
        end
        if (k == 3000) begin
            err_total++;
            $display("Error irq_out expected 1 seen %b", irq_out);
        end
        rd(ADDR_CONTROL, {6'h08, ch}, 8'hFF);
        level <= ~lv;
        rd(ADDR_RESULT_HIGH, s[8:1], 8'hFF);
        rd(ADDR_RESULT_LOW, {s[0], 7'h00}, 8'h80);
        rd(ADDR_IRQ_STATUS, 8'h01, 8'h01);
        wr(ADDR_IRQ_MASK, 8'h00);
        wr(ADDR_IRQ_MASK, 8'h01);
        wr(ADDR_IRQ_STATUS, 8'h01);
        rd(ADDR_IRQ_STATUS, 8'h00, 8'h01);
    endtask : conv
    // ------------------------------------------------------------
    // Read monitor and hang guard
    // ------------------------------------------------------------
    always @(posedge sys_clk_in) begin
        if (rd_seen === 1'b1) begin
            n_checks++;
            if ((reg_rdata_out & exp_q[0][15:8]) !==
                (exp_q[0][7:0] & exp_q[0][15:8])) begin
                err_total++;
                $display("Error reg_rdata_out expected %h seen %h",
                         exp_q[0][7:0], reg_rdata_out);
            end
            void'(exp_q.pop_front());
        end
        rd_seen <= reg_rd_in;
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            report_and_stop();
        end
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge sys_clk_in);
        sys_rst_in <= 1'b0;
        rd(ADDR_CONTROL, 8'h40, 8'hFF);
        wr(ADDR_CONTROL, 8'h1B);
        rd(ADDR_CONTROL, 8'h5B, 8'hFF);
        rd(ADDR_CLK_SEL, 8'h00, 8'h03);
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00, 8'hFF);
        wr(ADDR_IRQ_MASK, 8'h01);
        // Start held high: no completion, pending stays set
        wr(ADDR_CONTROL, 8'hA0);
        repeat (200) @(posedge sys_clk_in);
        rd(ADDR_CONTROL, 8'hE0, 8'hFF);
        rd(ADDR_IRQ_STATUS, 8'h00, 8'h01);
        // Pins off powers the converter down, so a pulse completes nothing
        wr(ADDR_CONTROL, 8'h80);
        wr(ADDR_CONTROL, 8'h00);
        repeat (200) @(posedge sys_clk_in);
        rd(ADDR_IRQ_STATUS, 8'h00, 8'h01);
        // Pins back on without a start pulse must complete nothing
        wr(ADDR_CONTROL, 8'h20);
        repeat (200) @(posedge sys_clk_in);
        rd(ADDR_IRQ_STATUS, 8'h00, 8'h01);
        // Divider code 11 gives no conversion clock, so a pulse stalls
        wr(ADDR_CLK_SEL, 8'h03);
        wr(ADDR_CONTROL, 8'hA0);
        wr(ADDR_CONTROL, 8'h20);
        repeat (100) @(posedge sys_clk_in);
        rd(ADDR_CONTROL, 8'h60, 8'hFF);
        rd(ADDR_IRQ_STATUS, 8'h00, 8'h01);
        for (int d = 0; d < 4; d++) begin
            conv(d == 3 ? 2'h2 : 2'(d), 2'(d));
        end
        repeat (3) @(posedge sys_clk_in);
        report_and_stop();
    end
endmodule : adc_sequencer_control_bench
bind adc_sequencer_control adc_seq_chk #(.RES_BITS(RES_BITS)) u_adc_seq_chk (
    .sys_clk_in(sys_clk_in), .sys_rst_in(sys_rst_in),
    .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .analog_sample_in(analog_sample_in),
    .pin_analog_out(pin_analog_out),
    .converter_power_out(converter_power_out), .irq_out(irq_out));
`default_nettype wire
